// file: flash_seq_pkg.sv
package flash_seq_pkg;
    // register indices, byte address is four times the index
    localparam logic [3:0]  IDX_LOCK_STATE    = 4'h1;
    localparam logic [3:0]  IDX_STATUS        = 4'h2;
    localparam logic [3:0]  IDX_CMD_INDEX     = 4'h3;
    localparam logic [3:0]  IDX_CMD_WORD      = 4'h4;
    localparam logic [3:0]  IDX_IRQ_STATUS    = 4'h5;
    localparam logic [3:0]  IDX_IRQ_MASK      = 4'h6;
    localparam logic [3:0]  IDX_PARTITION     = 4'h7;
    // configuration byte location
    localparam logic [22:0] CFG_BYTE_ADDR     = 23'h7FFF0F;
    // lock-state field layout
    localparam int          BACKDOOR_UNLOCK_ENABLE_POS         = 6;
    localparam int          SEC_POS           = 0;
    localparam logic [1:0]  BACKDOOR_UNLOCK_ENABLE_ENABLED     = 2'h2;
    localparam logic [1:0]  SEC_UNLOCKED      = 2'h2;
    localparam logic [7:0]  LOCK_FAULT_VALUE  = 8'hFF;
    // status register bits
    localparam int          ST_COMMAND_COMPLETE_FLAG           = 7;
    localparam int          ST_ACCERR         = 5;
    localparam int          ST_PVIOL          = 4;
    localparam int          ST_MC_ERR         = 1;
    localparam int          ST_MC_FATAL       = 0;
    // interrupt status bits
    localparam int          IRQ_DONE          = 0;
    localparam int          IRQ_ACCERR        = 1;
    localparam int          IRQ_MC_ERR        = 2;
    // command codes
    localparam logic [6:0]  CMD_ERASE_VERIFY  = 7'h10;
    localparam logic [6:0]  CMD_PROGRAM       = 7'h11;
    // command word index values
    localparam logic [2:0]  CIDX_ADDR_HI      = 3'h0;
    localparam logic [2:0]  CIDX_ADDR_LO      = 3'h1;
    localparam logic [2:0]  CIDX_WORD0        = 3'h2;
    localparam logic [2:0]  CIDX_WORD3        = 3'h5;
    // reset values
    localparam logic [15:0] PARTITION_RESET   = 16'h8000;
    localparam logic [2:0]  IRQ_MASK_RESET    = 3'h0;
    // memory controller operations
    typedef enum logic [1:0] {MC_PROGRAM, MC_VERIFY, MC_ERASE_VERIFY} mc_op_e;
endpackage

// file: flash_lock_loader.sv
`timescale 1ns/1ns
`default_nettype none
module flash_lock_loader
(
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    // configuration read port
    output logic             o_cfg_rd_req,
    output logic [22:0]      o_cfg_rd_addr,
    input  wire logic        i_cfg_rd_valid,
    input  wire logic [7:0]  i_cfg_rd_data,
    input  wire logic        i_cfg_dbl_fault,
    // result
    output logic             o_done,
    output logic [7:0]       o_lock_byte
);
    typedef struct packed {
        logic       req;
        logic       done;
        logic [7:0] lock_byte;
    } loader_s;

    loader_s cur;
    loader_s next_cur;

    always_comb
    begin
        next_cur = cur;
        if (cur.req && i_cfg_rd_valid)
        begin
            next_cur.req  = 1'b0;
            next_cur.done = 1'b1;
            // double fault leaves everything set: locked, no backdoor
            next_cur.lock_byte = i_cfg_dbl_fault ? flash_seq_pkg::LOCK_FAULT_VALUE : i_cfg_rd_data;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            cur <= '{req: 1'b1, done: 1'b0, lock_byte: flash_seq_pkg::LOCK_FAULT_VALUE};
        else
            cur <= next_cur;
    end

    assign o_cfg_rd_req  = cur.req;
    assign o_cfg_rd_addr = flash_seq_pkg::CFG_BYTE_ADDR;
    assign o_done        = cur.done;
    assign o_lock_byte   = cur.lock_byte;
endmodule
`default_nettype wire

// file: flash_seq.sv
// What this block does
// - lock-state register at index 0x0001, readable, software writes change nothing
// - lock-state register loaded from configuration byte during reset sequence
// - double-bit fault on that read sets every lock-state bit
// - backdoor unlock enabled only when enable field equals 10
// - backdoor unlock forces lock-state field to 10
// - erase-verify: access error unless command index equals 010 at launch
// - erase-verify: access error if a load-data-field sequence is active
// - program: access error if command not permitted in current mode (lock-state field not 10)
// - erase-verify: access error on invalid or odd global address
// - erase-verify: access error on partition address, block overrun, partition entry
// - erase-verify read sets error status, and fatal status on uncorrectable error
// - program writes one to four erased words and verifies each one
// - clearing complete flag launches; index at launch sets word count
// - program makes access-error checks only, no protection checks
// - complete flag set again when program finishes
`timescale 1ns/1ns
`default_nettype none
module flash_seq
#(
    parameter logic [22:0] DFLASH_BASE  = 23'h100000,
    parameter logic [22:0] DFLASH_BYTES = 23'h008000
)
(
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    // apb slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic             o_pready,
    output logic [31:0]      o_prdata,
    output logic             o_pslverr,
    // configuration read port
    output logic             o_cfg_rd_req,
    output logic [22:0]      o_cfg_rd_addr,
    input  wire logic        i_cfg_rd_valid,
    input  wire logic [7:0]  i_cfg_rd_data,
    input  wire logic        i_cfg_dbl_fault,
    // memory controller
    output logic             o_mc_req,
    output logic [1:0]       o_mc_op,
    output logic [22:0]      o_mc_addr,
    output logic [15:0]      o_mc_data,
    output logic [15:0]      o_mc_len,
    input  wire logic        i_mc_ack,
    input  wire logic        i_mc_err,
    input  wire logic        i_mc_fatal,
    // system
    input  wire logic        i_backdoor_unlock,
    input  wire logic        i_load_field_active,
    output logic             o_backdoor_enabled,
    output logic             o_irq
);
    typedef enum {SEQ_BOOT, SEQ_IDLE, SEQ_PROG, SEQ_VERIFY, SEQ_ERASE_VER} seq_e;

    typedef struct packed {
        seq_e              seq;
        logic              pready;
        logic [31:0]       prdata;
        logic              pslverr;
        logic [7:0]        lock_state;
        logic              command_complete_flag;
        logic              accerr;
        logic              pviol;
        logic              mc_err;
        logic              mc_fatal;
        logic [2:0]        cmd_index;
        logic [5:0][15:0]  cmd_words;
        logic [2:0]        irq_status;
        logic [2:0]        irq_mask;
        logic [15:0]       partition;
        logic [1:0]        word_cnt;
        logic [1:0]        word_last;
        logic              mc_req;
        flash_seq_pkg::mc_op_e mc_op;
        logic [22:0]       mc_addr;
        logic [15:0]       mc_data;
        logic [15:0]       mc_len;
        logic              backdoor_en;
        logic              irq;
    } seq_s;

    seq_s cur;
    seq_s next_cur;

    logic        loader_done;
    logic [7:0]  loader_byte;

    flash_lock_loader u_loader
    (
        .i_clk           (i_clk),
        .i_sys_rst       (i_sys_rst),
        .o_cfg_rd_req    (o_cfg_rd_req),
        .o_cfg_rd_addr   (o_cfg_rd_addr),
        .i_cfg_rd_valid  (i_cfg_rd_valid),
        .i_cfg_rd_data   (i_cfg_rd_data),
        .i_cfg_dbl_fault (i_cfg_dbl_fault),
        .o_done          (loader_done),
        .o_lock_byte     (loader_byte)
    );

    // decoded command fields
    logic [6:0]  cmd_code;
    logic [22:0] cmd_addr;
    logic [22:0] cmd_off;
    logic [22:0] cmd_end;
    logic [22:0] sect_bytes;
    logic [22:0] user_bytes;
    logic        locked;
    logic        addr_bad;
    logic        launch_err;
    logic [3:0]  reg_idx;
    logic        bus_access;
    logic        bus_done;
    logic [31:0] rd_value;
    logic        rd_mapped;

    assign cmd_code   = cur.cmd_words[0][14:8];
    assign cmd_addr   = {cur.cmd_words[0][6:0], cur.cmd_words[1]};
    assign cmd_off    = 23'(cmd_addr - DFLASH_BASE);
    assign user_bytes = {7'h00, cur.partition};
    assign locked     = cur.lock_state[flash_seq_pkg::SEC_POS +: 2] != flash_seq_pkg::SEC_UNLOCKED;
    assign reg_idx    = i_paddr[5:2];
    assign bus_access = i_psel && i_penable && (i_paddr[11:6] == 6'h00) && (i_paddr[1:0] == 2'h0);
    assign bus_done   = i_psel && i_penable && cur.pready;

    // section length in bytes: erase-verify takes it from word 2, program from the index
    always_comb
    begin
        if (cmd_code == flash_seq_pkg::CMD_ERASE_VERIFY)
            sect_bytes = {6'h00, cur.cmd_words[2], 1'b0};
        else
            sect_bytes = {18'h00000, 4'(cur.cmd_index - flash_seq_pkg::CIDX_ADDR_LO), 1'b0};
        cmd_end = 23'(cmd_off + sect_bytes);
    end

    // access checks common to both commands; program has no protection checks
    always_comb
    begin
        addr_bad = 1'b0;
        if ((cmd_addr < DFLASH_BASE) || (cmd_off >= DFLASH_BYTES) || cmd_addr[0])
            addr_bad = 1'b1;
        if ((cmd_off >= user_bytes) || (cmd_end > DFLASH_BYTES) || (cmd_end > user_bytes))
            addr_bad = 1'b1;
        launch_err = addr_bad;
        // codes above seven bits are unknown commands
        if (cur.cmd_words[0][15])
            launch_err = 1'b1;
        if (cmd_code == flash_seq_pkg::CMD_ERASE_VERIFY)
        begin
            if (cur.cmd_index != flash_seq_pkg::CIDX_WORD0)
                launch_err = 1'b1;
            if (i_load_field_active)
                launch_err = 1'b1;
        end
        else if (cmd_code == flash_seq_pkg::CMD_PROGRAM)
        begin
            if ((cur.cmd_index < flash_seq_pkg::CIDX_WORD0) || (cur.cmd_index > flash_seq_pkg::CIDX_WORD3))
                launch_err = 1'b1;
            if (locked)
                launch_err = 1'b1;
        end
        else
        begin
            launch_err = 1'b1;
        end
    end

    // register read mux
    always_comb
    begin
        rd_value  = 32'h00000000;
        rd_mapped = 1'b1;
        unique case (reg_idx)
            flash_seq_pkg::IDX_LOCK_STATE: rd_value[7:0] = cur.lock_state;
            flash_seq_pkg::IDX_STATUS:
            begin
                rd_value[flash_seq_pkg::ST_COMMAND_COMPLETE_FLAG]     = cur.command_complete_flag;
                rd_value[flash_seq_pkg::ST_ACCERR]   = cur.accerr;
                rd_value[flash_seq_pkg::ST_PVIOL]    = cur.pviol;
                rd_value[flash_seq_pkg::ST_MC_ERR]   = cur.mc_err;
                rd_value[flash_seq_pkg::ST_MC_FATAL] = cur.mc_fatal;
            end
            flash_seq_pkg::IDX_CMD_INDEX:  rd_value[2:0] = cur.cmd_index;
            flash_seq_pkg::IDX_CMD_WORD:
            begin
                if (cur.cmd_index <= flash_seq_pkg::CIDX_WORD3)
                    rd_value[15:0] = cur.cmd_words[cur.cmd_index];
            end
            flash_seq_pkg::IDX_IRQ_STATUS: rd_value[2:0] = cur.irq_status;
            flash_seq_pkg::IDX_IRQ_MASK:   rd_value[2:0] = cur.irq_mask;
            flash_seq_pkg::IDX_PARTITION:  rd_value[15:0] = cur.partition;
            default:                       rd_mapped = 1'b0;
        endcase
    end

    always_comb
    begin
        next_cur = cur;
        // apb: one wait cycle, then answer
        next_cur.pready  = 1'b0;
        next_cur.pslverr = 1'b0;
        if (i_psel && i_penable && !cur.pready)
        begin
            next_cur.pready  = 1'b1;
            next_cur.prdata  = i_pwrite ? 32'h00000000 : rd_value;
            next_cur.pslverr = !(bus_access && rd_mapped);
        end

        // write and read side effects at the completing edge
        if (bus_done && bus_access && !cur.pslverr)
        begin
            if (!i_pwrite && (reg_idx == flash_seq_pkg::IDX_IRQ_STATUS))
                next_cur.irq_status = 3'h0;
            if (i_pwrite)
            begin
                unique case (reg_idx)
                    flash_seq_pkg::IDX_STATUS:
                    begin
                        if (i_pwdata[flash_seq_pkg::ST_ACCERR])
                            next_cur.accerr = 1'b0;
                        if (i_pwdata[flash_seq_pkg::ST_PVIOL])
                            next_cur.pviol = 1'b0;
                        if (i_pwdata[flash_seq_pkg::ST_COMMAND_COMPLETE_FLAG] && cur.command_complete_flag && (cur.seq == SEQ_IDLE))
                        begin
                            if (launch_err)
                            begin
                                next_cur.accerr = 1'b1;
                                next_cur.irq_status[flash_seq_pkg::IRQ_ACCERR] = 1'b1;
                            end
                            else
                            begin
                                // clearing the flag launches the command
                                next_cur.command_complete_flag      = 1'b0;
                                next_cur.mc_err    = 1'b0;
                                next_cur.mc_fatal  = 1'b0;
                                next_cur.word_cnt  = 2'h0;
                                next_cur.word_last = 2'(cur.cmd_index - flash_seq_pkg::CIDX_WORD0);
                                next_cur.mc_req    = 1'b1;
                                next_cur.mc_addr   = cmd_addr;
                                next_cur.mc_len    = cur.cmd_words[2];
                                if (cmd_code == flash_seq_pkg::CMD_ERASE_VERIFY)
                                begin
                                    next_cur.seq   = SEQ_ERASE_VER;
                                    next_cur.mc_op = flash_seq_pkg::MC_ERASE_VERIFY;
                                end
                                else
                                begin
                                    next_cur.seq     = SEQ_PROG;
                                    next_cur.mc_op   = flash_seq_pkg::MC_PROGRAM;
                                    next_cur.mc_data = cur.cmd_words[flash_seq_pkg::CIDX_WORD0];
                                    next_cur.mc_len  = 16'h0001;
                                end
                            end
                        end
                    end
                    flash_seq_pkg::IDX_CMD_INDEX:
                    begin
                        if (cur.command_complete_flag)
                            next_cur.cmd_index = i_pwdata[2:0];
                    end
                    flash_seq_pkg::IDX_CMD_WORD:
                    begin
                        if (cur.command_complete_flag && (cur.cmd_index <= flash_seq_pkg::CIDX_WORD3))
                            next_cur.cmd_words[cur.cmd_index] = i_pwdata[15:0];
                    end
                    flash_seq_pkg::IDX_IRQ_MASK:  next_cur.irq_mask = i_pwdata[2:0];
                    flash_seq_pkg::IDX_PARTITION:
                    begin
                        if (cur.command_complete_flag)
                            next_cur.partition = i_pwdata[15:0];
                    end
                    default:
                    begin
                        // lock-state and others ignore writes
                        next_cur.lock_state = cur.lock_state;
                    end
                endcase
            end
        end

        // sequencer
        unique case (cur.seq)
            SEQ_BOOT:
            begin
                if (loader_done)
                begin
                    next_cur.lock_state = loader_byte;
                    next_cur.command_complete_flag       = 1'b1;
                    next_cur.seq        = SEQ_IDLE;
                end
            end
            SEQ_IDLE:
            begin
            end
            SEQ_PROG:
            begin
                if (i_mc_ack)
                begin
                    next_cur.seq   = SEQ_VERIFY;
                    next_cur.mc_op = flash_seq_pkg::MC_VERIFY;
                end
            end
            SEQ_VERIFY:
            begin
                if (i_mc_ack)
                begin
                    if (i_mc_err)
                        next_cur.mc_err = 1'b1;
                    if (i_mc_fatal)
                        next_cur.mc_fatal = 1'b1;
                    if (cur.word_cnt == cur.word_last)
                    begin
                        next_cur.mc_req = 1'b0;
                        next_cur.command_complete_flag   = 1'b1;
                        next_cur.seq    = SEQ_IDLE;
                        next_cur.irq_status[flash_seq_pkg::IRQ_DONE] = 1'b1;
                        if (i_mc_err || i_mc_fatal || cur.mc_err || cur.mc_fatal)
                            next_cur.irq_status[flash_seq_pkg::IRQ_MC_ERR] = 1'b1;
                    end
                    else
                    begin
                        next_cur.word_cnt = 2'(cur.word_cnt + 2'h1);
                        next_cur.mc_addr  = 23'(cur.mc_addr + 23'h000002);
                        next_cur.mc_data  = cur.cmd_words[3'(flash_seq_pkg::CIDX_WORD0 + {1'b0, cur.word_cnt} + 3'h1)];
                        next_cur.seq      = SEQ_PROG;
                        next_cur.mc_op    = flash_seq_pkg::MC_PROGRAM;
                    end
                end
            end
            SEQ_ERASE_VER:
            begin
                if (i_mc_ack)
                begin
                    next_cur.mc_err   = i_mc_err;
                    next_cur.mc_fatal = i_mc_fatal;
                    next_cur.mc_req   = 1'b0;
                    next_cur.command_complete_flag     = 1'b1;
                    next_cur.seq      = SEQ_IDLE;
                    next_cur.irq_status[flash_seq_pkg::IRQ_DONE] = 1'b1;
                    if (i_mc_err || i_mc_fatal)
                        next_cur.irq_status[flash_seq_pkg::IRQ_MC_ERR] = 1'b1;
                end
            end
        endcase

        // backdoor unlock forces the lock-state field open
        if (i_backdoor_unlock && cur.backdoor_en && (cur.seq != SEQ_BOOT))
            next_cur.lock_state[flash_seq_pkg::SEC_POS +: 2] = flash_seq_pkg::SEC_UNLOCKED;
        next_cur.backdoor_en = next_cur.lock_state[flash_seq_pkg::BACKDOOR_UNLOCK_ENABLE_POS +: 2] == flash_seq_pkg::BACKDOOR_UNLOCK_ENABLE_ENABLED;
        next_cur.irq = |(next_cur.irq_status & next_cur.irq_mask);
    end

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            cur            <= '0;
            cur.seq        <= SEQ_BOOT;
            cur.lock_state <= flash_seq_pkg::LOCK_FAULT_VALUE;
            cur.partition  <= flash_seq_pkg::PARTITION_RESET;
            cur.irq_mask   <= flash_seq_pkg::IRQ_MASK_RESET;
            cur.mc_op      <= flash_seq_pkg::MC_PROGRAM;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign o_pready           = cur.pready;
    assign o_prdata           = cur.prdata;
    assign o_pslverr          = cur.pslverr;
    assign o_mc_req           = cur.mc_req;
    assign o_mc_op            = cur.mc_op;
    assign o_mc_addr          = cur.mc_addr;
    assign o_mc_data          = cur.mc_data;
    assign o_mc_len           = cur.mc_len;
    assign o_backdoor_enabled = cur.backdoor_en;
    assign o_irq              = cur.irq;
endmodule
`default_nettype wire

// file: flash_seq_properties.sv
`timescale 1ns/1ns
`default_nettype none
module flash_seq_properties
#(
    parameter logic [22:0] DFLASH_BASE = 23'h100000
)
(
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    input  wire logic        o_pready,
    input  wire logic [31:0] o_prdata,
    input  wire logic        o_cfg_rd_req,
    input  wire logic [22:0] o_cfg_rd_addr,
    input  wire logic        i_cfg_rd_valid,
    input  wire logic        i_cfg_dbl_fault,
    input  wire logic        o_mc_req,
    input  wire logic [1:0]  o_mc_op,
    input  wire logic [22:0] o_mc_addr,
    input  wire logic [15:0] o_mc_len,
    input  wire logic        i_mc_ack,
    input  wire logic        o_backdoor_enabled
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    // status write with the complete bit set
    logic launch;
    assign launch = o_pready && i_pwrite && i_paddr == 12'h008 && i_pwdata[7];
    property p_cfg_addr; o_cfg_rd_req |-> o_cfg_rd_addr == 23'h7FFF0F; endproperty
    a_cfg_addr: assert property (p_cfg_addr) else $error("config read address wrong");
    property p_fault; i_cfg_rd_valid && i_cfg_dbl_fault && o_cfg_rd_req |-> ##4 !o_backdoor_enabled; endproperty
    a_fault: assert property (p_fault) else $error("backdoor enabled after faulty load");
    property p_lock_ro; o_pready && i_pwrite && i_paddr == 12'h004 |=> $stable(o_backdoor_enabled); endproperty
    a_lock_ro: assert property (p_lock_ro) else $error("lock state changed by write");
    property p_backdoor_unlock_enable; o_pready && !i_pwrite && i_paddr == 12'h004 |-> o_backdoor_enabled == (o_prdata[7:6] == 2'h2);
    endproperty
    a_backdoor_unlock_enable: assert property (p_backdoor_unlock_enable) else $error("backdoor enable disagrees with field");
    property p_start; $rose(o_mc_req) |-> $past(launch); endproperty
    a_start: assert property (p_start) else $error("operation started without launch");
    property p_verify; o_mc_req && i_mc_ack && o_mc_op == 2'h0 |=> o_mc_req && o_mc_op == 2'h1 && $stable(o_mc_addr);
    endproperty
    a_verify: assert property (p_verify) else $error("program not followed by verify");
    property p_next; o_mc_req && i_mc_ack && o_mc_op == 2'h1 ##1 o_mc_req |-> o_mc_op == 2'h0
        && o_mc_addr == $past(o_mc_addr) + 23'h2; endproperty
    a_next: assert property (p_next) else $error("next word address wrong");
    property p_len; o_mc_req && o_mc_op != 2'h2 |-> o_mc_len == 16'h1; endproperty
    a_len: assert property (p_len) else $error("program length not one word");
    property p_ev_done; o_mc_req && i_mc_ack && o_mc_op == 2'h2 |=> !o_mc_req; endproperty
    a_ev_done: assert property (p_ev_done) else $error("erase verify did not finish");
    property p_even; o_mc_req |-> !o_mc_addr[0] && o_mc_addr >= DFLASH_BASE; endproperty
    a_even: assert property (p_even) else $error("bad address reached controller");
endmodule
bind flash_seq flash_seq_properties #(.DFLASH_BASE(DFLASH_BASE)) u_props (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready), .o_prdata(o_prdata),
    .o_cfg_rd_req(o_cfg_rd_req), .o_cfg_rd_addr(o_cfg_rd_addr), .i_cfg_rd_valid(i_cfg_rd_valid),
    .i_cfg_dbl_fault(i_cfg_dbl_fault), .o_mc_req(o_mc_req), .o_mc_op(o_mc_op), .o_mc_addr(o_mc_addr),
    .o_mc_len(o_mc_len), .i_mc_ack(i_mc_ack), .o_backdoor_enabled(o_backdoor_enabled));
`default_nettype wire

// file: tb_flash_seq.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; $display("wrong value at %0t: %h %h", $time, a, b); end end
module tb_flash_seq;
    logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, vld = 0, flt = 0, ack = 0, merr = 0, mfat = 0;
    logic        unlock = 0, lfa = 0, pready, pslverr, se, cfg_req, mc_req, bd_en, irq;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [7:0]  cdat = 0;
    logic [22:0] cfg_addr, mc_addr, a;
    logic [15:0] mc_data, mc_len, wd [4];
    logic [1:0]  mc_op;
    int          errors = 0, comparisons = 0, seed = 32'h38f8f133, n, cnt;
    always #10 clk = ~clk;
    flash_seq DUT (.i_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
        .o_cfg_rd_req(cfg_req), .o_cfg_rd_addr(cfg_addr), .i_cfg_rd_valid(vld), .i_cfg_rd_data(cdat),
        .i_cfg_dbl_fault(flt), .o_mc_req(mc_req), .o_mc_op(mc_op), .o_mc_addr(mc_addr), .o_mc_data(mc_data),
        .o_mc_len(mc_len), .i_mc_ack(ack), .i_mc_err(merr), .i_mc_fatal(mfat), .i_backdoor_unlock(unlock),
        .i_load_field_active(lfa), .o_backdoor_enabled(bd_en), .o_irq(irq));
    function automatic logic bd_exp(input logic [7:0] b);
        return b[7:6] == 2'h2;
    endfunction
    task automatic wrap_up;
        if (errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic tmo(input int k, input int lim);
        if (k >= lim)
        begin
            errors++;
            wrap_up();
        end
    endtask
    task automatic apb(input logic w, input logic [3:0] i, input logic [31:0] d);
        int k;
        psel <= 1;
        pwr <= w;
        paddr <= {6'h0, i, 2'h0};
        pwdata <= d;
        @(posedge clk);
        pen <= 1;
        for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge clk);
        tmo(k, 20);
        rd = prdata;
        se = pslverr;
        psel <= 0;
        pen <= 0;
        @(posedge clk);
    endtask
    task automatic rdchk(input logic [3:0] i, input logic [31:0] e);
        apb(1'b0, i, 32'h0);
        `CHK(rd, e)
    endtask
    task automatic ld(input logic [2:0] i, input logic [15:0] v);
        apb(1'b1, 4'h3, {29'h0, i});
        apb(1'b1, 4'h4, {16'h0, v});
    endtask
    // code and address words, then cnt data words
    task automatic load(input logic [7:0] c, input logic [22:0] ad, input int k);
        ld(3'h0, {c, 1'b0, ad[22:16]});
        ld(3'h1, ad[15:0]);
        for (int j = 0; j < k; j++) ld(3'(2 + j), wd[j]);
    endtask
    task automatic boot(input logic [7:0] b, input logic f);
        rst <= 1;
        repeat (6) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        `CHK(cfg_addr, 23'h7FFF0F)
        vld <= 1;
        cdat <= b;
        flt <= f;
        @(posedge clk);
        vld <= 0;
        for (n = 0; n < 10 && cfg_req !== 1'b0; n++) @(posedge clk);
        tmo(n, 10);
        repeat (3) @(posedge clk);
    endtask
    // launch that must be refused, then clear the error
    task automatic bad;
        apb(1'b1, 4'h2, 32'h80);
        `CHK(mc_req, 1'b0)
        rdchk(4'h2, 32'hA0);
        apb(1'b1, 4'h2, 32'h20);
        rdchk(4'h5, 32'h2);
    endtask
    // answers nops controller requests with random delays
    task automatic serve(input logic [1:0] op0, input int nops, input logic e);
        for (int j = 0; j < nops; j++)
        begin
            for (n = 0; n < 50 && mc_req !== 1'b1; n++) @(posedge clk);
            tmo(n, 50);
            #1;
            `CHK(mc_op, (op0 == 2'h2) ? op0 : 2'(j % 2))
            `CHK(mc_addr, a + 23'(2 * (j / 2)))
            if (op0 == 2'h0) `CHK(mc_data, wd[j / 2])
            `CHK(mc_len, (op0 == 2'h2) ? wd[0] : 16'h1)
            repeat (1 + {$random(seed)} % 4) @(posedge clk);
            ack <= 1;
            merr <= e;
            mfat <= e;
            @(posedge clk);
            ack <= 0;
        end
        repeat (2) @(posedge clk);
        `CHK(mc_req, 1'b0)
    endtask
    initial
    begin
        boot(8'hBE, 1'b1);
        rdchk(4'h1, 32'hFF);
        `CHK(bd_en, 1'b0)
        apb(1'b0, 4'hF, 32'h0);
        `CHK(se, 1'b1)
        for (int k = 0; k < 4; k++)
        begin
            boot({2'(k), 6'h3E}, 1'b0);
            `CHK(bd_en, bd_exp({2'(k), 6'h3E}))
            rdchk(4'h1, {24'h0, 2'(k), 6'h3E});
        end
        boot(8'hBF, 1'b0);
        apb(1'b1, 4'h6, 32'h7);
        a = 23'h100000;
        load(8'h11, a, 1);
        bad();
        apb(1'b1, 4'h1, 32'h0);
        rdchk(4'h1, 32'hBF);
        unlock <= 1;
        @(posedge clk);
        unlock <= 0;
        repeat (2) @(posedge clk);
        rdchk(4'h1, 32'hBE);
        for (int i = 0; i < 4; i++)
        begin
            cnt = (i == 0) ? 4 : 1 + {$random(seed)} % 4;
            a = 23'h100000 + 23'(i * 32'h1000) + 23'({$random(seed)} & 32'hFF8);
            foreach (wd[j]) wd[j] = 16'($random(seed));
            load(8'h11, a, cnt);
            apb(1'b1, 4'h2, 32'h80);
            serve(2'h0, 2 * cnt, 1'b0);
            rdchk(4'h2, 32'h80);
            `CHK(irq, 1'b1)
            rdchk(4'h5, 32'h1);
            @(posedge clk);
            `CHK(irq, 1'b0)
        end
        load(8'h11, a, 0);
        bad();
        load(8'h11, a | 23'h1, 1);
        bad();
        load(8'h11, 23'h107FFE, 2);
        bad();
        a = 23'h100000;
        wd[0] = 16'h4;
        load(8'h10, a, 1);
        apb(1'b1, 4'h3, 32'h1);
        bad();
        apb(1'b1, 4'h3, 32'h2);
        lfa <= 1;
        bad();
        lfa <= 0;
        apb(1'b1, 4'h2, 32'h80);
        serve(2'h2, 1, 1'b1);
        rdchk(4'h2, 32'h83);
        rdchk(4'h5, 32'h5);
        wrap_up();
    end
    initial
    begin
        #1000000;
        errors++;
        wrap_up();
    end
endmodule
`default_nettype wire
